/* File: gds_defines.vh */
// Constants for the gauge driver serial slave: word layout and timing.
// Assumes a 25 MHz reference clock; included by bare name.
`ifndef GDS_DEFINES_VH
`define GDS_DEFINES_VH
// Word layout
`define GDS_WORD_BITS 16
`define GDS_CNT_BITS 4
`define GDS_ADDR_HI 15
`define GDS_ADDR_LO 13
`define GDS_DATA_HI 12
// Reset values
`define GDS_WORD_RST 16'h0000
`define GDS_CNT_RST 4'h0
// Buffer
`define GDS_FIFO_DEPTH 8
`define GDS_FIFO_AW 3
// Timing: least chip-select high time, and reference rate
`define GDS_CS_GAP_NS 5000
`define GDS_REF_CLK_KHZ 25000
`define GDS_CS_GAP_CYC ((`GDS_CS_GAP_NS * `GDS_REF_CLK_KHZ + 999999) / 1000000)
`endif

/* File: gds_fifo.v */
// Word FIFO between the serial front end and the register write port.
// Assumes one clock and a synchronous, active-high reset.
module gds_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             i_ref_clk,  // Clock
	input  wire             i_rst,      // Sync reset
	input  wire             i_in_valid, // Write request
	output wire             o_in_ready, // Not full
	input  wire [WIDTH-1:0] i_in_data,  // Write word
	output wire             o_out_valid,// Not empty
	input  wire             i_out_ready,// Read accept
	output wire [WIDTH-1:0] o_out_data  // Head word
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0]    wp_q;
	reg [AW-1:0]    rp_q;
	reg [AW:0]      cnt_q;
	wire            push;
	wire            pop;

	// Honest flags from the occupancy count
	assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
	assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
	assign o_out_data  = mem_q[rp_q];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// Storage write, no reset needed on data
	always @(posedge i_ref_clk)
	begin
		if (push)
			mem_q[wp_q] <= i_in_data;
	end

	// Pointers wrap; depth assumed a power of two
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			wp_q  <= {AW{1'b0}};
			rp_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // gds_fifo

/* File: gds_spi_slave.v */
// Serial slave of a dual gauge driver: shifts words in and status out.
// Assumes pins are asynchronous to i_ref_clk and the serial clock is
// at most one eighth of the reference rate.
// Notes on behaviour
// - Chip-select rise copies the received word to the addressed register.
// - Serial output driven only while chip select is low.
// - Clock and data pins are ignored while chip select is high.
// - Serial input is sampled on each falling serial clock edge.
// - Serial output advances on each rising serial clock edge.
// - Words are 16 bits, most significant bit first both ways.
// - Bit counts not a multiple of 16 discard the message.
// - First 16 bits shifted out are the status word.
// - Beyond 16 bits, earlier received bits follow in arrival order.
// - First rising serial clock edge loads the status word.
// - Bits 15 to 13 of the word select the destination register.
// - Works at a 333 ns symmetric serial clock and slower.
`include "gds_defines.vh"

module gds_spi_slave #(
	parameter FIFO_DEPTH = `GDS_FIFO_DEPTH,
	parameter FIFO_AW    = `GDS_FIFO_AW
) (
	input  wire        i_ref_clk,    // 25 MHz clock
	input  wire        i_rst,        // Sync reset
	input  wire        i_cs_n,       // Chip select pin
	input  wire        i_sclk,       // Serial clock pin
	input  wire        i_si,         // Serial data in pin
	input  wire [15:0] i_status,     // Status word
	output wire        o_so,         // Serial data out
	output wire        o_so_oe,      // Out enable
	input  wire        i_wr_ready,   // Register side accept
	output wire        o_wr_valid,   // Register write
	output wire [2:0]  o_wr_addr,    // Register select
	output wire [12:0] o_wr_data,    // Register data
	output wire        o_msg_drop,   // Bad length pulse
	output wire        o_gap_short,  // Short gap pulse
	output wire        o_ovfl        // Lost word pulse
);
	localparam integer GAP_INT = `GDS_CS_GAP_CYC;
	localparam [11:0]  GAP_CYC = GAP_INT[11:0];

	////////////////////////////////////////////////////////////////
	// Field decoders
	////////////////////////////////////////////////////////////////

	// Destination select
	function [2:0] word_addr;
		input [`GDS_WORD_BITS-1:0] w;
		begin
			word_addr = w[`GDS_ADDR_HI:`GDS_ADDR_LO];
		end
	endfunction

	// Payload below the select
	function [12:0] word_data;
		input [`GDS_WORD_BITS-1:0] w;
		begin
			word_data = w[`GDS_DATA_HI:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// Pin synchronisers
	////////////////////////////////////////////////////////////////

	reg cs_m_q;
	reg cs_s_q;
	reg cs_p_q;
	reg sck_m_q;
	reg sck_s_q;
	reg sck_p_q;
	reg si_m_q;
	reg si_s_q;

	// two-stage crossing
	// Every pin passes two flops; first stages feed nothing else
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			cs_m_q  <= 1'b1;
			cs_s_q  <= 1'b1;
			cs_p_q  <= 1'b1;
			sck_m_q <= 1'b0;
			sck_s_q <= 1'b0;
			sck_p_q <= 1'b0;
			si_m_q  <= 1'b0;
			si_s_q  <= 1'b0;
		end
		else
		begin
			cs_m_q  <= i_cs_n;
			cs_s_q  <= cs_m_q;
			cs_p_q  <= cs_s_q;
			sck_m_q <= i_sclk;
			sck_s_q <= sck_m_q;
			sck_p_q <= sck_s_q;
			si_m_q  <= i_si;
			si_s_q  <= si_m_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Edge detection
	////////////////////////////////////////////////////////////////

	wire win;
	wire sck_fall;
	wire sck_rise;
	wire cs_fall;
	wire cs_rise;

	// gate edges
	// Window taken from the delayed select so the last clock edge
	// that lands with the select rise is still counted
	assign win      = ~cs_p_q;
	// edge finding
	// A 333 ns clock gives over three samples per phase
	assign sck_fall = win & sck_p_q & ~sck_s_q;
	assign sck_rise = win & ~sck_p_q & sck_s_q;
	assign cs_fall  = cs_p_q & ~cs_s_q;
	assign cs_rise  = ~cs_p_q & cs_s_q;

	////////////////////////////////////////////////////////////////
	// Shift path
	////////////////////////////////////////////////////////////////

	reg [`GDS_WORD_BITS-1:0] sr_q;
	reg [`GDS_WORD_BITS-1:0] sr_d;
	reg [`GDS_CNT_BITS-1:0]  cnt_q;
	reg [`GDS_CNT_BITS-1:0]  cnt_d;
	reg                      any_q;
	reg                      any_d;
	reg                      first_q;
	reg                      so_q;
	reg                      oe_q;

	// One register serves both ways: status is loaded, then each
	// received bit enters at the bottom and leaves 16 bits later
	always @*
	begin
		sr_d  = sr_q;
		cnt_d = cnt_q;
		any_d = any_q;
		if (sck_rise && first_q)
		begin
			sr_d = i_status;
		end
		else if (sck_fall)
		begin
			sr_d  = {sr_q[`GDS_WORD_BITS-2:0], si_s_q};
			cnt_d = cnt_q + 1'b1;
			any_d = 1'b1;
		end
	end

	// Shift state and first-edge marker
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			sr_q    <= `GDS_WORD_RST;
			cnt_q   <= `GDS_CNT_RST;
			any_q   <= 1'b0;
			first_q <= 1'b0;
		end
		else if (cs_rise)
		begin
			sr_q    <= sr_d;
			cnt_q   <= `GDS_CNT_RST;
			any_q   <= 1'b0;
			first_q <= 1'b0;
		end
		else
		begin
			sr_q  <= sr_d;
			cnt_q <= cnt_d;
			any_q <= any_d;
			if (cs_fall)
				first_q <= 1'b1;
			else if (sck_rise)
				first_q <= 1'b0;
		end
	end

	// Output bit and its enable
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			so_q <= 1'b0;
			oe_q <= 1'b0;
		end
		else
		begin
			oe_q <= ~cs_s_q;
			if (cs_s_q)
				so_q <= 1'b0;
			else if (sck_rise && first_q)
				so_q <= i_status[`GDS_WORD_BITS-1];
			else if (sck_rise)
				so_q <= sr_q[`GDS_WORD_BITS-1];
		end
	end

	assign o_so    = so_q;
	assign o_so_oe = oe_q;

	////////////////////////////////////////////////////////////////
	// Message commit
	////////////////////////////////////////////////////////////////

	wire                     good_len;
	reg                      pend_q;
	reg [`GDS_WORD_BITS-1:0] pend_w_q;
	reg                      drop_q;
	reg                      ovfl_q;
	wire                     f_in_rdy;

	// length check
	// Count wraps every 16 bits, so zero with bits seen is a multiple
	assign good_len = any_d && (cnt_d == `GDS_CNT_RST);

	// Completed word waits here until the FIFO takes it
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			pend_q   <= 1'b0;
			pend_w_q <= `GDS_WORD_RST;
			drop_q   <= 1'b0;
			ovfl_q   <= 1'b0;
		end
		else
		begin
			drop_q <= cs_rise & any_d & ~good_len;
			ovfl_q <= 1'b0;
			if (cs_rise && good_len)
			begin
				if (pend_q && !f_in_rdy)
					// Older word kept; newer one lost
					ovfl_q <= 1'b1;
				else
				begin
					pend_q   <= 1'b1;
					pend_w_q <= sr_d;
				end
			end
			else if (pend_q && f_in_rdy)
				pend_q <= 1'b0;
		end
	end

	assign o_msg_drop = drop_q;
	assign o_ovfl     = ovfl_q;

	////////////////////////////////////////////////////////////////
	// Chip-select gap monitor
	////////////////////////////////////////////////////////////////

	reg [11:0] gap_q;
	reg        gap_run_q;
	reg        gap_short_q;

	// least high time
	// Only reported; the master owns this timing
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			gap_q       <= 12'h000;
			gap_run_q   <= 1'b0;
			gap_short_q <= 1'b0;
		end
		else
		begin
			gap_short_q <= cs_fall & gap_run_q & (gap_q < GAP_CYC);
			if (cs_rise)
			begin
				gap_q     <= 12'h001; // Rise cycle is the first high cycle
				gap_run_q <= 1'b1;
			end
			else if (cs_s_q && gap_q != GAP_CYC)
				gap_q <= gap_q + 12'h001;
		end
	end

	assign o_gap_short = gap_short_q;

	////////////////////////////////////////////////////////////////
	// Buffer and write port
	////////////////////////////////////////////////////////////////

	wire                     f_out_vld;
	wire [`GDS_WORD_BITS-1:0] f_out_dat;
	wire                     f_pop;
	reg                      wv_q;
	reg [2:0]                wa_q;
	reg [12:0]               wd_q;

	assign f_pop = f_out_vld & (~wv_q | i_wr_ready);

	gds_fifo #(
		.WIDTH (`GDS_WORD_BITS),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.i_ref_clk   (i_ref_clk),
		.i_rst       (i_rst),
		.i_in_valid  (pend_q),
		.o_in_ready  (f_in_rdy),
		.i_in_data   (pend_w_q),
		.o_out_valid (f_out_vld),
		.i_out_ready (f_pop),
		.o_out_data  (f_out_dat)
	);

	// Output stage holds the write until accepted
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			wv_q <= 1'b0;
			wa_q <= 3'h0;
			wd_q <= 13'h0000;
		end
		else if (f_pop)
		begin
			wv_q <= 1'b1;
			wa_q <= word_addr(f_out_dat);
			wd_q <= word_data(f_out_dat);
		end
		else if (i_wr_ready)
			wv_q <= 1'b0;
	end

	assign o_wr_valid = wv_q;
	assign o_wr_addr  = wa_q;
	assign o_wr_data  = wd_q;
endmodule // gds_spi_slave

/* File: gds_spi_slave_monitor.sv */
// Checker on the serial slave ports.
// Assumes i_ref_clk at 25 MHz and pins driven on falling edges.
module gds_mon (
	input logic        i_ref_clk,   // Clock
	input logic        i_rst,       // Sync reset
	input logic        i_cs_n,      // Chip select pin
	input logic        i_sclk,      // Serial clock pin
	input logic        i_wr_ready,  // Write accept
	input logic        o_so,        // Serial out
	input logic        o_so_oe,     // Out enable
	input logic        o_wr_valid,  // Write pending
	input logic [2:0]  o_wr_addr,   // Write select
	input logic [12:0] o_wr_data,   // Write data
	input logic        o_msg_drop,  // Bad length
	input logic        o_gap_short, // Short gap
	input logic        o_ovfl       // Lost word
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	////////////////////////////////////////////////////////////////
	a_oe_off_idle: assert property (i_cs_n [*5] |-> !o_so_oe && !o_so)
		else $error("serial out driven while deselected");
	a_oe_on_window: assert property (!i_cs_n [*5] |-> o_so_oe)
		else $error("serial out not driven in window");
	// Pin path is three flops deep, so a change trails the rise
	a_so_on_rise: assert property ($changed(o_so) && o_so_oe |-> $past(i_sclk, 3))
		else $error("serial out moved off a rising clock");
	a_wr_hold: assert property (o_wr_valid && !i_wr_ready
		|=> o_wr_valid && $stable({o_wr_addr, o_wr_data}))
		else $error("write dropped before accept");
	a_wr_after_cs: assert property ($rose(o_wr_valid) |-> i_cs_n)
		else $error("write raised inside a window");
	a_drop_pulse: assert property (o_msg_drop |-> i_cs_n ##1 !o_msg_drop)
		else $error("bad length flag malformed");
	a_gap_pulse: assert property (o_gap_short |-> !i_cs_n ##1 !o_gap_short)
		else $error("short gap flag malformed");
	a_ovfl_pulse: assert property (o_ovfl |-> o_wr_valid ##1 !o_ovfl)
		else $error("lost word flag malformed");
endmodule // gds_mon

bind gds_spi_slave gds_mon u_gds_mon (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cs_n(i_cs_n),
	.i_sclk(i_sclk), .i_wr_ready(i_wr_ready), .o_so(o_so), .o_so_oe(o_so_oe),
	.o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
	.o_msg_drop(o_msg_drop), .o_gap_short(o_gap_short), .o_ovfl(o_ovfl));

/* File: gds_master.sv */
// Serial bus master model: select, clock and data toward the slave.
// Assumes the bench clock; all changes land on its falling edge.
module gds_master (
	input  logic i_ref_clk, // Bench clock
	input  logic i_so_pin,  // Resolved out pin
	output logic o_cs_n,    // Chip select
	output logic o_sclk,    // Serial clock
	output logic o_si       // Serial data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] rx_q; // Bits seen on the pin
	// Idle: deselected, clock low
	initial
	begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_si = 1'b0;
		rx_q = 32'h0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge i_ref_clk);
	endtask
	// data set at rise, taken at fall, 320 ns bit
	task automatic bitx(input logic b);
		o_si = b;
		o_sclk = 1'b1;
		wt(4);
		o_sclk = 1'b0;
		wt(4);
		rx_q = {rx_q[30:0], i_so_pin}; // Late read, well after the rise
	endtask
	task automatic word(input logic [15:0] w);
		for (int i = 15; i >= 0; i--)
			bitx(w[i]);
	endtask
	// select moves only with the clock low
	task automatic sel(input logic lvl, input int n);
		o_cs_n = lvl;
		o_si = ~o_si; // Stale line never repeats its old bit
		wt(n);
	endtask
endmodule // gds_master

/* File: gds_spi_slave_tb_top.sv */
// Self-checking bench for the gauge serial slave.
// Assumes the master model and the bound checker are compiled first.
module gds_spi_slave_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0;
	logic        rst;
	logic        wr_ready;
	logic [15:0] status;
	logic        cs_n, sclk, si, so, so_oe, wr_valid, drop, gap, ovfl;
	logic [2:0]  wr_addr;
	logic [12:0] wr_data;
	wire         so_pin = so_oe ? so : 1'bz;
	int          n_mismatch = 0, samples_checked = 0, n_drop = 0, n_gap = 0, n_ovfl = 0;
	logic [15:0] got[$];
	logic [31:0] rows[8] = '{32'h8001_0ABC, 32'h7E3C_2F01, 32'h5AA5_4123, 32'h0000_6E55,
		32'hFFFF_81C3, 32'h1234_A0FF, 32'hC0DE_D3AA, 32'h3C96_FFFF}; // {status, word}
	always #20 ref_clk = ~ref_clk;
	gds_spi_slave u_gds_spi_slave (.i_ref_clk(ref_clk), .i_rst(rst), .i_cs_n(cs_n),
		.i_sclk(sclk), .i_si(si), .i_status(status), .o_so(so), .o_so_oe(so_oe),
		.i_wr_ready(wr_ready), .o_wr_valid(wr_valid), .o_wr_addr(wr_addr),
		.o_wr_data(wr_data), .o_msg_drop(drop), .o_gap_short(gap), .o_ovfl(ovfl));
	gds_master u_gds_master (.i_ref_clk(ref_clk), .i_so_pin(so_pin), .o_cs_n(cs_n),
		.o_sclk(sclk), .o_si(si));
	// Log accepted writes and event pulses
	always @(posedge ref_clk)
	begin
		if (wr_valid === 1'b1 && wr_ready === 1'b1)
			got.push_back({wr_addr, wr_data});
		n_drop += (drop === 1'b1);
		n_gap += (gap === 1'b1);
		n_ovfl += (ovfl === 1'b1);
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic frame(input logic [15:0] w, input int g);
		u_gds_master.sel(1'b0, 4);
		u_gds_master.word(w);
		u_gds_master.sel(1'b1, g);
	endtask
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog well past the expected 300 us
	initial
	begin
		#1000000;
		n_mismatch++;
		close_out();
	end
	// Main sequence
	initial
	begin
		rst = 1'b1;
		wr_ready = 1'b1;
		status = 16'h0000;
		repeat (3) @(negedge ref_clk);
		rst = 1'b0;
		chk("oe_rst", 0, so_oe);
		chk("wr_rst", 0, wr_valid);
		u_gds_master.wt(4);
		$display("test reset done");
		// One row per destination code, full gap after each
		foreach (rows[i])
		begin
			status = rows[i][31:16];
			frame(rows[i][15:0], 130);
			chk("status", rows[i][31:16], u_gds_master.rx_q[15:0]);
			chk("write", rows[i][15:0], got.pop_front());
		end
		$display("test table done");
		// Two words in one window: echo follows status, last word kept
		u_gds_master.sel(1'b0, 4);
		u_gds_master.word(16'hA55A);
		chk("oe_on", 1, so_oe);
		u_gds_master.word(16'h6C3F);
		u_gds_master.sel(1'b1, 130);
		chk("echo", {status, 16'hA55A}, u_gds_master.rx_q);
		chk("last", 16'h6C3F, got.pop_front());
		chk("oe_off", 0, so_oe);
		$display("test chain done");
		// Twenty bits, then clocking while deselected
		u_gds_master.sel(1'b0, 4);
		u_gds_master.word(16'h2F0F);
		repeat (4) u_gds_master.bitx(1'b1);
		u_gds_master.sel(1'b1, 20);
		repeat (16) u_gds_master.bitx(1'b0);
		u_gds_master.wt(130);
		chk("drop", 1, n_drop);
		chk("nwr", 0, got.size());
		$display("test length done");
		// One cycle short is flagged, the exact limit is not; all words land
		frame(16'h4321, 124);
		frame(16'h8765, 125);
		frame(16'h1357, 130);
		chk("gap", 1, n_gap);
		chk("w1", 16'h4321, got.pop_front());
		chk("w2", 16'h8765, got.pop_front());
		chk("w3", 16'h1357, got.pop_front());
		$display("test gap done");
		// Stall the write side until words are lost, then drain
		wr_ready = 1'b0;
		for (int i = 0; i < 12; i++)
			frame(16'h1000 + i, 130);
		// Stage, eight slots and the pending word hold ten; two are lost
		chk("ovfl", 2, n_ovfl);
		wr_ready = 1'b1;
		u_gds_master.wt(40);
		chk("kept", 10, got.size());
		for (int i = 0; i < 10; i++)
			chk("fifo", 16'h1000 + i, got.pop_front());
		$display("test buffer done");
		// Reset inside a window: partial bits forgotten, no write, no drop
		u_gds_master.sel(1'b0, 4);
		repeat (8) u_gds_master.bitx(1'b1);
		rst = 1'b1;
		u_gds_master.wt(3);
		rst = 1'b0;
		chk("oe_mid_rst", 0, so_oe);
		chk("wr_mid_rst", 0, wr_valid);
		u_gds_master.wt(8);
		chk("oe_resume", 1, so_oe);
		u_gds_master.sel(1'b1, 130);
		chk("drop_rst", 1, n_drop);
		chk("nwr_rst", 0, got.size());
		$display("test mid reset done");
		close_out();
	end
endmodule // gds_spi_slave_tb_top
